// >>> sdrc_pkg.sv
// shared constants, field positions and carriers for the memory controller
package sdrc_pkg;
    // register byte offsets
    localparam logic [11:0] OFS_MODE = 12'h100;
    localparam logic [11:0] OFS_CTRL = 12'h104;
    localparam logic [11:0] OFS_CFGA = 12'h108;
    localparam logic [11:0] OFS_CFGB = 12'h10C;
    localparam logic [11:0] OFS_BSEL = 12'h110;
    // control field positions (lsb numbering)
    localparam int CT_MODE_EN = 31;
    localparam int CT_CLK_STOP = 30;
    localparam int CT_DDR = 29;
    localparam int CT_REF_DIS = 28;
    localparam int CT_ASEL_HI = 25;
    localparam int CT_ASEL_LO = 24;
    localparam int CT_NARROW = 23;
    localparam int CT_DRIVE = 22;
    localparam int CT_POI_HI = 21;
    localparam int CT_POI_LO = 16;
    localparam int CT_DQS_HI = 11;
    localparam int CT_DQS_LO = 8;
    localparam int CT_BUF = 4;
    // mode data: bank address then twelve address lines
    localparam int MD_BA_HI = 13;
    localparam int MD_BA_LO = 12;
    localparam int MD_A_HI = 11;
    // bank select register
    localparam int BS_HI = 9;
    localparam int BS_TWO = 8;
    // precharge control address lines
    localparam int PRE_NARROW = 8;
    localparam int PRE_WIDE = 10;
    // slow tick for refresh and page counters
    localparam int DIV_RATIO = 64;
    localparam int DIV_W = 6;
    localparam int POI_W = 6;
    localparam logic [31:0] RESET_WORD = 32'h0000_0000;

    typedef struct packed {
        logic [1:0] csN;
        logic       rasN;
        logic       casN;
        logic       weN;
    } sdrc_cmd_s;

    localparam sdrc_cmd_s CMD_NOP = '{2'h3, 1'b1, 1'b1, 1'b1};
    localparam sdrc_cmd_s CMD_MRS = '{2'h0, 1'b0, 1'b0, 1'b0};
    localparam sdrc_cmd_s CMD_REF = '{2'h0, 1'b0, 1'b0, 1'b1};

    typedef struct packed {
        logic [3:0] singleRdToWr;
        logic [2:0] singleWrToRd;
        logic [4:0] readLatency;
        logic [2:0] actToAccess;
        logic [2:0] preToAct;
        logic [3:0] refToAct;
        logic [3:0] writeLatency;
        logic [3:0] burstRdToPre;
        logic [3:0] burstWrToAccess;
        logic [3:0] burstRdToWr;
        logic [3:0] burstLength;
        logic [2:0] readTap;
    } sdrc_delay_s;

    // delay register layouts, reserved gaps kept in place
    typedef struct packed {
        logic [3:0] singleRdToWr;
        logic       rsv0;
        logic [2:0] singleWrToRd;
        logic [3:0] readLatency;
        logic       rsv1;
        logic [2:0] actToAccess;
        logic       rsv2;
        logic [2:0] preToAct;
        logic [3:0] refToAct;
        logic       rsv3;
        logic [2:0] writeLatency;
        logic [3:0] rsv4;
    } sdrc_cfga_s;

    typedef struct packed {
        logic [3:0]  burstRdToPre;
        logic [3:0]  burstWrToAccess;
        logic [3:0]  burstRdToWr;
        logic [3:0]  burstLength;
        logic [12:0] rsv;
        logic [2:0]  readTap;
    } sdrc_cfgb_s;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_MRS  = 2'b01,
        ST_REF  = 2'b11,
        ST_GAP  = 2'b10
    } sdrc_state_e;

    // buffered modules add one clock to data latencies
    function automatic logic [4:0] sdrc_lat_adj(input logic [3:0] lat,
                                                input logic       buff);
        sdrc_lat_adj = {1'b0, lat} + {4'h0, buff};
    endfunction : sdrc_lat_adj
endpackage : sdrc_pkg

// >>> sdrc_tick_div.sv
// divide-by-64 enable pulse for the page and refresh counters
`timescale 1ns/1ps
module sdrc_tick_div (
    input  wire logic clk_sys,
    input  wire logic rst_b,
    output logic      tick
);
    logic [sdrc_pkg::DIV_W-1:0] count;

    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
            count <= '0;
        else
            count <= count + 1'b1;
    end

    assign tick = (count == sdrc_pkg::DIV_W'(sdrc_pkg::DIV_RATIO - 1));
endmodule : sdrc_tick_div

// >>> sdrc_countdown.sv
// reloadable down counter with terminal count, held at zero until reload
`timescale 1ns/1ps
module sdrc_countdown #(
    parameter int W = 6
) (
    input  wire logic         clk_sys,
    input  wire logic         rst_b,
    input  wire logic         tick,
    input  wire logic         run,
    input  wire logic         load,
    input  wire logic [W-1:0] origin,
    output logic              done
);
    logic [W-1:0] count;

    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
            count <= '0;
        else if (load)
            count <= origin;
        else if (tick && run && count != '0)
            count <= count - 1'b1;
    end

    assign done = (count == '0);
endmodule : sdrc_countdown

// >>> sdrc_regs.sv
// memory controller registers, mode set, refresh and pin control
//
// How it works
// - register picked by offset under chip select
// - registers cleared by power-up reset only
// - mode register write issues mode-set command
// - mode bits 18..31 go to bank, address
// - mode writes accepted only while enable set
// - control bit 0 enables mode writes
// - control bit 1 stops memory clock
// - control bit 2 selects double data rate
// - refresh counter runs unless bit 3 set
// - control bits 6:7 select address multiplexing
// - bit 8 moves precharge line A10 to A8
// - bit 9 chooses data pin drive policy
// - bits 10:15 page interval in slow ticks
// - bits 20:23 enable individual data strobes
// - buffered modules delay mask, add latency
// - first delay register supplies command gaps
// - second delay register supplies burst gaps
// - bank select routes high address bits
// - counters reload after refresh or precharge
`timescale 1ns/1ps
module sdrc_regs (
    input  wire logic              clk_sys,
    input  wire logic              rst_b,
    input  wire logic              warmRst_b,
    input  wire logic              regChipSel,
    input  wire logic              regWrite,
    input  wire logic              regRead,
    input  wire logic [11:0]       regOffset,
    input  wire logic [31:0]       regWdata,
    output logic [31:0]            regRdata,
    input  wire logic [1:0]        busAddrHigh,
    input  wire logic              cmdRead,
    input  wire logic              cmdWrite,
    input  wire logic [3:0]        dmIn,
    input  wire logic [1:0]        refreshIssued,
    input  wire logic [1:0]        prechargeIssued,
    output sdrc_pkg::sdrc_cmd_s    memCmd,
    output logic [1:0]             memBa,
    output logic [11:0]            memAddr,
    output logic                   ownCmdValid,
    output logic                   memClkRun,
    output logic                   ddrMode,
    output logic [1:0]             addrSel,
    output logic [11:0]            prechargeBit,
    output logic                   dqOe,
    output logic [3:0]             dqsOe,
    output logic [3:0]             memDm,
    output logic [1:0]             bankCsN,
    output logic [1:0]             pageExpired,
    output logic [1:0]             refreshDue,
    output logic                   activateAllowed,
    output sdrc_pkg::sdrc_delay_s  cmdDelays
);
    ////////////////////////////////////////////////////////////////////
    // register decode
    logic [31:0] ctrlReg;
    sdrc_pkg::sdrc_cfga_s cfgA;
    sdrc_pkg::sdrc_cfgb_s cfgB;
    logic [15:0] bselReg;
    wire wrStb = regChipSel && regWrite;
    wire rdStb = regChipSel && regRead;
    wire hitMode = regOffset == sdrc_pkg::OFS_MODE;
    wire hitCtrl = regOffset == sdrc_pkg::OFS_CTRL;
    wire hitCfgA = regOffset == sdrc_pkg::OFS_CFGA;
    wire hitCfgB = regOffset == sdrc_pkg::OFS_CFGB;
    wire hitBsel = regOffset == sdrc_pkg::OFS_BSEL;
    wire modeEn = ctrlReg[sdrc_pkg::CT_MODE_EN];
    // mode data is never stored, it only rides the command
    wire modeAccept = wrStb && hitMode && modeEn;
    wire refDis = ctrlReg[sdrc_pkg::CT_REF_DIS];
    wire buffered = ctrlReg[sdrc_pkg::CT_BUF];
    wire driveAll = ctrlReg[sdrc_pkg::CT_DRIVE];
    wire [3:0] dqsEn = ctrlReg[sdrc_pkg::CT_DQS_HI:sdrc_pkg::CT_DQS_LO];
    wire [sdrc_pkg::POI_W-1:0] pageInterval =
        ctrlReg[sdrc_pkg::CT_POI_HI:sdrc_pkg::CT_POI_LO];

    // warm resets leave the registers alone
    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
        begin
            ctrlReg <= sdrc_pkg::RESET_WORD;
            cfgA <= sdrc_pkg::RESET_WORD;
            cfgB <= sdrc_pkg::RESET_WORD;
            bselReg <= sdrc_pkg::RESET_WORD[15:0];
        end
        else if (wrStb)
        begin
            if (hitCtrl)
                ctrlReg <= regWdata;
            if (hitCfgA)
                cfgA <= regWdata;
            if (hitCfgB)
                cfgB <= regWdata;
            if (hitBsel)
                bselReg <= regWdata[15:0];
        end
    end

    // only the bank select register reads back
    wire [31:0] next_rdata = (rdStb && hitBsel) ?
        {16'h0000, bselReg} : sdrc_pkg::RESET_WORD;

    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
            regRdata <= sdrc_pkg::RESET_WORD;
        else if (rdStb)
            regRdata <= next_rdata;
    end

    ////////////////////////////////////////////////////////////////////
    // refresh, page and gap counters
    wire logicRst_b = rst_b && warmRst_b;
    logic slowTick;
    logic [1:0] refDone;
    logic [1:0] preDone;
    logic gapDone;
    logic issueRef;
    logic loadGap;
    logic [3:0] gapOrigin;

    sdrc_tick_div u_div (
        .clk_sys (clk_sys),
        .rst_b   (logicRst_b),
        .tick    (slowTick)
    );

    for (genvar b = 0; b < 2; b++)
    begin : g_bank
        sdrc_countdown #(.W(sdrc_pkg::POI_W)) u_ref (
            .clk_sys (clk_sys),
            .rst_b   (logicRst_b),
            .tick    (slowTick),
            .run     (!refDis),
            .load    (issueRef || refreshIssued[b]),
            .origin  (pageInterval),
            .done    (refDone[b])
        );
        sdrc_countdown #(.W(sdrc_pkg::POI_W)) u_page (
            .clk_sys (clk_sys),
            .rst_b   (logicRst_b),
            .tick    (slowTick),
            .run     (1'b1),
            .load    (prechargeIssued[b]),
            .origin  (pageInterval),
            .done    (preDone[b])
        );
    end

    // refresh-to-activate or precharge-to-activate guard
    sdrc_countdown #(.W(4)) u_gap (
        .clk_sys (clk_sys),
        .rst_b   (logicRst_b),
        .tick    (1'b1),
        .run     (1'b1),
        .load    (loadGap),
        .origin  (gapOrigin),
        .done    (gapDone)
    );
    assign loadGap = issueRef || (|prechargeIssued);
    assign gapOrigin = issueRef ? cfgA.refToAct
                                : {1'b0, cfgA.preToAct};

    ////////////////////////////////////////////////////////////////////
    // own command sequencer: mode set and auto refresh
    sdrc_pkg::sdrc_state_e state;
    sdrc_pkg::sdrc_state_e next_state;
    sdrc_pkg::sdrc_cmd_s next_cmd;
    logic [13:0] next_modeBits;
    wire refreshPending = (|refDone) && !refDis;

    always_comb
    begin
        next_state = state;
        next_cmd = sdrc_pkg::CMD_NOP;
        next_modeBits = 14'h0000;
        issueRef = 1'b0;
        // mode set outranks refresh; a pending refresh just waits
        if (modeAccept)
        begin
            next_state = sdrc_pkg::ST_MRS;
            next_cmd = sdrc_pkg::CMD_MRS;
            next_modeBits = regWdata[sdrc_pkg::MD_BA_HI:0];
        end
        else
        begin
            unique case (state)
                sdrc_pkg::ST_IDLE:
                    if (refreshPending && gapDone)
                    begin
                        next_state = sdrc_pkg::ST_REF;
                        next_cmd = sdrc_pkg::CMD_REF;
                        issueRef = 1'b1;
                    end
                sdrc_pkg::ST_MRS:
                    next_state = sdrc_pkg::ST_IDLE;
                sdrc_pkg::ST_REF:
                    next_state = sdrc_pkg::ST_GAP;
                sdrc_pkg::ST_GAP:
                    if (gapDone)
                        next_state = sdrc_pkg::ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!logicRst_b)
        begin
            state <= sdrc_pkg::ST_IDLE;
            memCmd <= sdrc_pkg::CMD_NOP;
            ownCmdValid <= 1'b0;
            memBa <= 2'h0;
            memAddr <= 12'h000;
        end
        else
        begin
            state <= next_state;
            memCmd <= next_cmd;
            ownCmdValid <= next_cmd != sdrc_pkg::CMD_NOP;
            memBa <= next_modeBits[sdrc_pkg::MD_BA_HI:sdrc_pkg::MD_BA_LO];
            memAddr <= next_modeBits[sdrc_pkg::MD_A_HI:0];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // pin policy and configuration outputs
    wire next_dqOe = driveAll ? !cmdRead : cmdWrite;
    // with no strobe enabled, strobe 0 alone serves single-strobe parts
    wire [3:0] strobeSel = (dqsEn == 4'h0) ? 4'h1 : dqsEn;
    wire ddrSel = ctrlReg[sdrc_pkg::CT_DDR];
    wire [3:0] next_dqsOe = strobeSel & {4{next_dqOe && ddrSel}};
    wire [11:0] next_preBit = ctrlReg[sdrc_pkg::CT_NARROW] ?
        12'(1 << sdrc_pkg::PRE_NARROW) : 12'(1 << sdrc_pkg::PRE_WIDE);
    wire twoSel = bselReg[sdrc_pkg::BS_TWO];
    wire [1:0] next_csN = (twoSel && busAddrHigh[0]) ? 2'h1 : 2'h2;
    logic [3:0] dmStage;
    sdrc_pkg::sdrc_delay_s next_delays;

    always_comb
    begin
        next_delays.singleRdToWr = cfgA.singleRdToWr;
        next_delays.singleWrToRd = cfgA.singleWrToRd;
        next_delays.readLatency = sdrc_pkg::sdrc_lat_adj(cfgA.readLatency,
                                                       buffered);
        next_delays.actToAccess = cfgA.actToAccess;
        next_delays.preToAct = cfgA.preToAct;
        next_delays.refToAct = cfgA.refToAct;
        next_delays.writeLatency = 4'(sdrc_pkg::sdrc_lat_adj(
            {1'b0, cfgA.writeLatency}, buffered));
        next_delays.burstRdToPre = cfgB.burstRdToPre;
        next_delays.burstWrToAccess = cfgB.burstWrToAccess;
        next_delays.burstRdToWr = cfgB.burstRdToWr;
        next_delays.burstLength = cfgB.burstLength;
        next_delays.readTap = cfgB.readTap;
    end

    always_ff @(posedge clk_sys)
    begin
        if (!logicRst_b)
        begin
            memClkRun <= 1'b1;
            ddrMode <= 1'b0;
            addrSel <= 2'h0;
            prechargeBit <= 12'(1 << sdrc_pkg::PRE_WIDE);
            dqOe <= 1'b0;
            dqsOe <= 4'h0;
            dmStage <= 4'h0;
            memDm <= 4'h0;
            bankCsN <= 2'h3;
            pageExpired <= 2'h0;
            refreshDue <= 2'h0;
            activateAllowed <= 1'b1;
            cmdDelays <= '0;
        end
        else
        begin
            memClkRun <= !ctrlReg[sdrc_pkg::CT_CLK_STOP];
            ddrMode <= ddrSel;
            addrSel <=
                ctrlReg[sdrc_pkg::CT_ASEL_HI:sdrc_pkg::CT_ASEL_LO];
            prechargeBit <= next_preBit;
            dqOe <= next_dqOe;
            dqsOe <= next_dqsOe;
            dmStage <= dmIn;
            memDm <= buffered ? dmStage : dmIn;
            bankCsN <= next_csN;
            pageExpired <= preDone;
            refreshDue <= refDone & {2{!refDis}};
            activateAllowed <= gapDone;
            cmdDelays <= next_delays;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // checks
    // a refused mode write may still meet a refresh in the next cycle
    a_mode_gated: assert property (
        @(posedge clk_sys) disable iff (!rst_b)
        (warmRst_b && wrStb && hitMode && !modeEn)
            |=> memCmd != sdrc_pkg::CMD_MRS)
        else $error("mode write passed while disabled");

    a_mode_issue: assert property (
        @(posedge clk_sys) disable iff (!rst_b)
        (warmRst_b && modeAccept) |=> (memCmd == sdrc_pkg::CMD_MRS
            && {memBa, memAddr} == $past(regWdata[sdrc_pkg::MD_BA_HI:0])))
        else $error("mode set command or data wrong");

    a_clock_stop: assert property (
        @(posedge clk_sys) disable iff (!rst_b)
        (warmRst_b && wrStb && hitCtrl && regWdata[sdrc_pkg::CT_CLK_STOP])
            ##1 warmRst_b |=> !memClkRun)
        else $error("clock still running after stop");

    a_ref_blocked: assert property (
        @(posedge clk_sys) disable iff (!rst_b)
        $past(refDis) |-> memCmd != sdrc_pkg::CMD_REF)
        else $error("refresh issued while disabled");

    a_drive_read: assert property (
        @(posedge clk_sys) disable iff (!rst_b)
        (warmRst_b && driveAll && cmdRead) |=> !dqOe)
        else $error("data pins driven during read");

    a_drive_idle: assert property (
        @(posedge clk_sys) disable iff (!rst_b)
        (warmRst_b && !driveAll && !cmdWrite) |=> !dqOe)
        else $error("data pins driven outside write");

    a_mask_delay: assert property (
        @(posedge clk_sys) disable iff (!rst_b)
        (warmRst_b && buffered)[*3] |-> memDm == $past(dmIn, 2))
        else $error("mask not delayed for buffered module");

    a_gap_hold: assert property (
        @(posedge clk_sys) disable iff (!rst_b)
        (warmRst_b && issueRef && cfgA.refToAct > 4'h1) ##1 warmRst_b
            |=> !activateAllowed)
        else $error("activate allowed right after refresh");

    a_bank_route: assert property (
        @(posedge clk_sys) disable iff (!rst_b)
        (warmRst_b && twoSel && busAddrHigh[0]) |=> bankCsN == 2'h1)
        else $error("bank select not routed");

    a_regs_keep: assert property (
        @(posedge clk_sys) disable iff (!rst_b)
        (!warmRst_b && !wrStb) |=> $stable(ctrlReg) && $stable(cfgA))
        else $error("warm reset disturbed registers");
endmodule : sdrc_regs

// >>> sdrc_mem_model.sv
// behavioural memory device that watches the controller's command pins
`timescale 1ns/1ps
module sdrc_mem_model (
    input  wire logic                clk_sys,
    input  wire logic                memClkRun,
    input  wire sdrc_pkg::sdrc_cmd_s memCmd,
    input  wire logic [1:0]          memBa,
    input  wire logic [11:0]         memAddr,
    output logic [13:0]              modeWord,
    output int                       refCount,
    output int                       badRef
);
    initial
    begin
        modeWord = 14'h0000;
        refCount = 0;
        badRef = 0;
    end

    ////////////////////////////////////////////////////////////////////////
    always @(posedge clk_sys)
    begin
        // a stopped clock means the device latches no command at all
        if (memClkRun === 1'b1)
        begin
            if (memCmd === sdrc_pkg::CMD_MRS)
                modeWord <= {memBa, memAddr};
            if (memCmd.rasN === 1'b0 && memCmd.casN === 1'b0 &&
                memCmd.weN === 1'b1)
            begin
                refCount <= refCount + 1;
                // both ranks must see the refresh
                if (memCmd.csN !== 2'h0)
                    badRef <= badRef + 1;
            end
        end
    end
endmodule : sdrc_mem_model

// >>> sdrc_regs_bench.sv
// self-checking bench for the memory controller register block
`timescale 1ns/1ps
module sdrc_regs_bench;
    logic                  clk_sys, rst_b, warmRst_b, regChipSel;
    logic                  regWrite, regRead, cmdRead, cmdWrite;
    logic [11:0]           regOffset, prechargeBit, memAddr;
    logic [31:0]           regWdata, regRdata, c, ca, cb, bs;
    logic [1:0]            busAddrHigh, refreshIssued, prechargeIssued;
    logic [1:0]            memBa, addrSel, bankCsN, pageExpired, refreshDue;
    logic [3:0]            dmIn, memDm, dqsOe, dmA, dmB;
    logic                  ownCmdValid, memClkRun, ddrMode, dqOe;
    logic                  activateAllowed, expOe;
    logic [15:0]           w;
    logic [13:0]           modeWord;
    logic [13:0]           mrsQueue [$];
    sdrc_pkg::sdrc_cmd_s   memCmd;
    sdrc_pkg::sdrc_delay_s cmdDelays, expD;
    int                    nErrors, samplesChecked, refCount, badRef, r0, t;
    logic [1:0]            opModes [3] = '{2'h0, 2'h2, 2'h1};

    sdrc_regs DUT (.clk_sys(clk_sys), .rst_b(rst_b), .warmRst_b(warmRst_b),
        .regChipSel(regChipSel), .regWrite(regWrite), .regRead(regRead),
        .regOffset(regOffset), .regWdata(regWdata), .regRdata(regRdata),
        .busAddrHigh(busAddrHigh), .cmdRead(cmdRead), .cmdWrite(cmdWrite),
        .dmIn(dmIn), .refreshIssued(refreshIssued),
        .prechargeIssued(prechargeIssued), .memCmd(memCmd), .memBa(memBa),
        .memAddr(memAddr), .ownCmdValid(ownCmdValid), .memClkRun(memClkRun),
        .ddrMode(ddrMode), .addrSel(addrSel), .prechargeBit(prechargeBit),
        .dqOe(dqOe), .dqsOe(dqsOe), .memDm(memDm), .bankCsN(bankCsN),
        .pageExpired(pageExpired), .refreshDue(refreshDue),
        .activateAllowed(activateAllowed), .cmdDelays(cmdDelays));

    sdrc_mem_model MEM (.clk_sys(clk_sys), .memClkRun(memClkRun),
        .memCmd(memCmd), .memBa(memBa), .memAddr(memAddr),
        .modeWord(modeWord), .refCount(refCount), .badRef(badRef));

    ////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [63:0] e,
                         input logic [63:0] g);
        samplesChecked++;
        if (g !== e)
        begin
            nErrors++;
            $display("wrong value %s expected %h seen %h", what, e, g);
        end
    endtask : check

    task automatic give_verdict;
        if (nErrors == 0 && samplesChecked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : give_verdict

    // one strobe per call; consecutive calls give back-to-back accesses
    task automatic bus(input logic wr, input logic [11:0] ofs,
                       input logic [31:0] d);
        @(posedge clk_sys);
        regChipSel <= 1'b1;
        regWrite <= wr;
        regRead <= !wr;
        regOffset <= ofs;
        regWdata <= d;
    endtask : bus

    task automatic idle(input int n);
        @(posedge clk_sys);
        regChipSel <= 1'b0;
        regWrite <= 1'b0;
        regRead <= 1'b0;
        prechargeIssued <= 2'h0;
        refreshIssued <= 2'h0;
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : idle

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end

    // every mode-set on the pins must match the oldest noted write
    always @(posedge clk_sys)
    begin
        if (rst_b === 1'b1 && memCmd === sdrc_pkg::CMD_MRS)
        begin
            if (mrsQueue.size() == 0)
                check("spurious mode set", 0, 1);
            else
                check("mode pins", mrsQueue.pop_front(), {memBa, memAddr});
            check("ownCmdValid", 1, ownCmdValid);
        end
    end

    initial
    begin
        {regChipSel, regWrite, regRead, cmdRead, cmdWrite} = 5'h00;
        {regOffset, regWdata, busAddrHigh, dmIn} = 50'h0;
        {refreshIssued, prechargeIssued} = 4'h0;
        rst_b = 1'b0;
        warmRst_b = 1'b1;
        nErrors = 0;
        samplesChecked = 0;
        void'($urandom(32'h425716A4));
        repeat (8) @(posedge clk_sys);
        rst_b <= 1'b1;
        idle(1);
        check("clk after reset", 1, memClkRun);
        check("pre after reset", 12'h400, prechargeBit);
        bus(1, sdrc_pkg::OFS_MODE, 32'h0000_0233);
        idle(4);
        bus(1, sdrc_pkg::OFS_CTRL, 32'h9000_0000);
        idle(2);
        for (int i = 0; i < 3; i++)
        begin
            // reserved zero, sequential burst of eight, CAS 2 or 3
            w = {4'($urandom), 3'h0, opModes[i], 3'(2 + $urandom % 2), 4'h3};
            mrsQueue.push_back(w[13:0]);
            bus(1, sdrc_pkg::OFS_MODE, {16'h0000, w});
        end
        idle(3);
        check("mode sets left", 0, mrsQueue.size());
        check("mode latched", w[13:0], modeWord);
        bus(1, sdrc_pkg::OFS_CTRL, 32'h1000_0000);
        bus(1, sdrc_pkg::OFS_MODE, 32'h0000_1033);
        idle(4);
        check("mode kept", w[13:0], modeWord);
        for (int i = 0; i < 4; i++)
        begin
            c = $urandom & 32'h73FF_0F10;
            ca = $urandom & 32'hF7F7_7770;
            cb = ($urandom & 32'hFFF0_0007) | 32'h0007_0000;
            bs = ($urandom % 2) ? 32'h100 : 32'h0;
            dmA = 4'($urandom);
            dmB = ~dmA;
            bus(1, sdrc_pkg::OFS_CTRL, c);
            {cmdRead, cmdWrite, busAddrHigh} <= 4'($urandom);
            dmIn <= dmA;
            bus(1, sdrc_pkg::OFS_CFGA, ca);
            bus(1, sdrc_pkg::OFS_CFGB, cb);
            bus(1, 12'h114, 32'hFFFF_FFFF);
            bus(1, sdrc_pkg::OFS_BSEL, bs);
            idle(3);
            expOe = c[22] ? !cmdRead : cmdWrite;
            expD = {ca[31:28], ca[26:24], 5'(ca[23:20]) + 5'(c[4]),
                    ca[18:16], ca[14:12], ca[11:8], 4'(ca[6:4]) + 4'(c[4]),
                    cb[31:28], cb[27:24], cb[23:20], cb[19:16], cb[2:0]};
            check("memClkRun", !c[30], memClkRun);
            check("ddrMode", c[29], ddrMode);
            check("addrSel", c[25:24], addrSel);
            check("prechargeBit", c[23] ? 12'h100 : 12'h400, prechargeBit);
            check("dqOe", expOe, dqOe);
            check("dqsOe", {4{expOe & c[29]}} &
                  ((c[11:8] != 4'h0) ? c[11:8] : 4'h1), dqsOe);
            check("cmdDelays", expD, cmdDelays);
            check("bankCsN", (bs[8] && busAddrHigh[0]) ? 2'h1 : 2'h2, bankCsN);
            @(posedge clk_sys);
            dmIn <= dmB;
            @(posedge clk_sys);
            #1;
            check("memDm", c[4] ? dmA : dmB, memDm);
            bus(0, sdrc_pkg::OFS_BSEL, 0);
            idle(2);
            check("bank select read", bs, regRdata);
            bus(0, 12'h114, 0);
            idle(2);
            check("unmapped read", 0, regRdata);
        end
        // warm reset keeps registers, power-up reset clears them
        bus(1, sdrc_pkg::OFS_CTRL, 32'h3000_0000);
        warmRst_b <= 1'b0;
        idle(3);
        warmRst_b <= 1'b1;
        idle(2);
        check("ddr after warm", 1, ddrMode);
        rst_b <= 1'b0;
        idle(3);
        rst_b <= 1'b1;
        idle(2);
        check("ddr after cold", 0, ddrMode);
        check("refresh due", 2'h3, refreshDue);
        bus(1, sdrc_pkg::OFS_CTRL, 32'h1000_0000);
        bus(1, sdrc_pkg::OFS_CFGA, 32'h0000_6000);
        idle(3);
        prechargeIssued <= 2'h1;
        idle(3);
        check("gap after precharge", 0, activateAllowed);
        t = 0;
        while (activateAllowed !== 1'b1 && t < 20)
        begin
            @(posedge clk_sys);
            #1;
            t++;
        end
        check("gap ends", 1, activateAllowed);
        bus(1, sdrc_pkg::OFS_CFGA, 32'h0000_0200);
        bus(1, sdrc_pkg::OFS_CTRL, 32'h0001_0000);
        refreshIssued <= 2'h3;
        r0 = refCount;
        idle(400);
        check("refresh runs", 1, (refCount - r0) >= 3);
        bus(1, sdrc_pkg::OFS_CTRL, 32'h1001_0000);
        idle(3);
        r0 = refCount;
        idle(300);
        check("refresh stopped", r0, refCount);
        check("refresh selects", 0, badRef);
        // bank 1 page reopened with a one-tick interval, bank 0 long expired
        prechargeIssued <= 2'h2;
        idle(1);
        check("page open", 2'h1, pageExpired);
        check("refresh due off", 0, refreshDue);
        idle(70);
        check("page expired", 2'h3, pageExpired);
        give_verdict();
    end
endmodule : sdrc_regs_bench
